//--- logic/srm_top.sv
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - The array decodes at any base aligned to its size, and overlapping the control block while running hides the block.
// - Byte and aligned word accesses complete in one bus cycle of two clocks.
// - Long word and misaligned word accesses take two successive bus cycles.
// - The control block answers unused locations with zero and ignores writes to them.
// - Base address writes take effect only while stopped and unlocked.
// - The lock bit can be set once and then holds until reset.
// - Space field bit 0 selects program and data (0) or program only (1); bit 1 is ignored.
// - No array access is accepted while running from the standby supply.
// - Reset sets stop, enables program space, and clears both bases and the lock.
// - A synchronous reset waits for a byte or word access to finish.
// - A synchronous reset in the first half of a long word ends it after that half.
// - There are four control registers and the two base registers form the array base.
module srm_top
    import srm_pkg::*;
#(
    parameter int unsigned ARRAY_BYTES = 1024,
    parameter logic [ADDR_W-1:0] REG_BLOCK_ADDR = 24'hfffb40
) (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // System state.
    input wire logic sync_rst_i,
    input wire logic standby_supply_i,
    input wire logic module_mapping_bit_i,
    // Array access port.
    input wire logic req_i,
    input wire srm_req_s req_data_i,
    output logic ack_o,
    output logic abort_o,
    output logic [DATA_W-1:0] rdata_o,
    // AXI4-Lite register slave.
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [AXI_AW-1:0] s_awaddr,
    input wire logic s_wvalid,
    output logic s_wready,
    input wire logic [DATA_W-1:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    output logic s_bvalid,
    input wire logic s_bready,
    output logic [1:0] s_bresp,
    input wire logic s_arvalid,
    output logic s_arready,
    input wire logic [AXI_AW-1:0] s_araddr,
    output logic s_rvalid,
    input wire logic s_rready,
    output logic [DATA_W-1:0] s_rdata,
    output logic [1:0] s_rresp
);
    localparam int unsigned IDX_W = $clog2(ARRAY_BYTES / 2);
    localparam logic [ADDR_W-1:0] OFS_MASK = ADDR_W'(ARRAY_BYTES - 1);

    if (ARRAY_BYTES < 8 || ARRAY_BYTES > 65536 || (ARRAY_BYTES & (ARRAY_BYTES - 1)) != 0) begin
        $error("ARRAY_BYTES must be a power of two from 8 to 65536");
    end

    srm_state_s r_q, r_d;
    logic [ADDR_W-1:0] base;
    logic hit, need_two_in, accept, rst_hit, rst_apply, hidden, last, need_two;
    logic ram_en, ram_we;
    logic [1:0] ram_be;
    logic [IDX_W-1:0] ram_idx, widx;
    logic [HALF_W-1:0] ram_wd, ram_rd;

    function automatic logic [HALF_W-1:0] merge(input logic [HALF_W-1:0] old,
                                                input logic [DATA_W-1:0] wd,
                                                input logic [3:0] strb);
        logic [HALF_W-1:0] v;
        v = old;
        if (strb[0]) begin
            v[7:0] = wd[7:0];
        end
        if (strb[1]) begin
            v[15:8] = wd[15:8];
        end
        return v;
    endfunction

    function automatic logic [DATA_W-1:0] reg_read(input srm_regs_s g,
                                                   input logic [AXI_AW-1:0] a);
        logic [HALF_W-1:0] cfg;
        cfg = '0;
        cfg[CFG_STOP_BIT] = g.stop;
        cfg[CFG_LOCK_BIT] = g.lock;
        cfg[CFG_SPACE_LSB +: 2] = g.space;
        unique case (a)
            OFF_CFG: reg_read = {16'h0000, cfg};
            OFF_TST: reg_read = {16'h0000, g.test};
            OFF_BAH: reg_read = {24'h00_0000, g.base_hi};
            OFF_BAL: reg_read = {16'h0000, g.base_lo};
            default: reg_read = READ_ZERO;
        endcase
    endfunction

    // The two base registers together name the array base.
    assign base = {r_q.regs.base_hi, r_q.regs.base_lo} & ~OFS_MASK;
    assign hit = (req_data_i.addr & ~OFS_MASK) == base;
    // A live array over the control block shadows it until reset.
    assign hidden = !r_q.regs.stop && ((REG_BLOCK_ADDR & ~OFS_MASK) == base);
    assign need_two_in = req_data_i.size == SZ_LONG
                         || (req_data_i.size == SZ_WORD && req_data_i.addr[0]);
    assign need_two = r_q.req.size == SZ_LONG
                      || (r_q.req.size == SZ_WORD && r_q.req.addr[0]);
    assign rst_hit = r_q.pend || sync_rst_i;
    // Reset is acted on only between accesses.
    assign rst_apply = r_q.st == ST_IDLE && rst_hit;
    assign accept = r_q.st == ST_IDLE && !rst_hit && !r_q.ack && req_i && hit
                    && module_mapping_bit_i
                    && !r_q.regs.stop
                    && !standby_supply_i
                    && (!r_q.regs.space[0] || req_data_i.prog_space);
    // A long word cut by reset stops after its first half.
    assign last = !need_two || r_q.cyc || (r_q.req.size == SZ_LONG && rst_hit);
    assign widx = r_q.req.addr[IDX_W:1];

    // Word lanes for the current bus cycle; even byte addresses use the upper lane.
    always_comb begin
        ram_en = r_q.st == ST_FETCH;
        ram_we = r_q.req.write;
        ram_idx = widx + IDX_W'(r_q.cyc);
        ram_be = 2'b11;
        ram_wd = r_q.req.wdata[15:0];
        unique case (r_q.req.size)
            SZ_BYTE: begin
                ram_be = r_q.req.addr[0] ? 2'b01 : 2'b10;
                ram_wd = {r_q.req.wdata[7:0], r_q.req.wdata[7:0]};
            end
            SZ_WORD: begin
                if (r_q.req.addr[0]) begin
                    ram_be = r_q.cyc ? 2'b10 : 2'b01;
                    ram_wd = r_q.cyc ? {r_q.req.wdata[7:0], 8'h00}
                                     : {8'h00, r_q.req.wdata[15:8]};
                end
            end
            SZ_LONG: begin
                ram_wd = r_q.cyc ? r_q.req.wdata[15:0] : r_q.req.wdata[31:16];
            end
            default: begin
                ram_be = 2'b00;
            end
        endcase
    end

    srm_word_ram #(
        .IDX_W(IDX_W)
    ) u_ram (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .en_i(ram_en),
        .we_i(ram_we),
        .be_i(ram_be),
        .idx_i(ram_idx),
        .wd_i(ram_wd),
        .rd_o(ram_rd)
    );

    always_comb begin
        r_d = r_q;
        r_d.ack = 1'b0;
        if (sync_rst_i) begin
            r_d.pend = 1'b1;
        end
        unique case (r_q.st)
            ST_IDLE: begin
                if (accept) begin
                    r_d.req = req_data_i;
                    r_d.cyc = 1'b0;
                    r_d.abort = 1'b0;
                    r_d.rdata = '0;
                    r_d.st = ST_FETCH;
                end
            end
            ST_FETCH: begin
                r_d.st = ST_LATCH;
            end
            ST_LATCH: begin
                unique case (r_q.req.size)
                    SZ_BYTE: r_d.rdata[7:0] = r_q.req.addr[0] ? ram_rd[7:0] : ram_rd[15:8];
                    SZ_WORD: begin
                        if (!r_q.req.addr[0]) begin
                            r_d.rdata[15:0] = ram_rd;
                        end else if (r_q.cyc) begin
                            r_d.rdata[7:0] = ram_rd[15:8];
                        end else begin
                            r_d.rdata[15:8] = ram_rd[7:0];
                        end
                    end
                    SZ_LONG: begin
                        if (r_q.cyc) begin
                            r_d.rdata[15:0] = ram_rd;
                        end else begin
                            r_d.rdata[31:16] = ram_rd;
                        end
                    end
                    default: r_d.rdata = r_q.rdata;
                endcase
                if (last) begin
                    r_d.st = ST_IDLE;
                    r_d.ack = 1'b1;
                    r_d.abort = need_two && !r_q.cyc;
                end else begin
                    r_d.cyc = 1'b1;
                    r_d.st = ST_FETCH;
                end
            end
            default: r_d.st = ST_IDLE;
        endcase

        // Register slave: address and data are taken independently.
        if (s_awvalid && s_awready) begin
            r_d.axi.aw_held = 1'b1;
            r_d.axi.awaddr = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            r_d.axi.w_held = 1'b1;
            r_d.axi.wdata = s_wdata;
            r_d.axi.wstrb = s_wstrb;
        end
        if (s_bvalid && s_bready) begin
            r_d.axi.bvalid = 1'b0;
        end
        if (r_q.axi.aw_held && r_q.axi.w_held && !r_q.axi.bvalid) begin
            r_d.axi.aw_held = 1'b0;
            r_d.axi.w_held = 1'b0;
            r_d.axi.bvalid = 1'b1;
            if (!hidden) begin
                unique case (r_q.axi.awaddr)
                    OFF_CFG: begin
                        if (r_q.axi.wstrb[1]) begin
                            r_d.regs.stop = r_q.axi.wdata[CFG_STOP_BIT];
                            // Set once, then frozen until reset.
                            r_d.regs.lock = r_q.regs.lock | r_q.axi.wdata[CFG_LOCK_BIT];
                            r_d.regs.space = r_q.axi.wdata[CFG_SPACE_LSB +: 2];
                        end
                    end
                    OFF_TST: r_d.regs.test = merge(r_q.regs.test, r_q.axi.wdata,
                                                   r_q.axi.wstrb);
                    OFF_BAH: begin
                        if (r_q.regs.stop && !r_q.regs.lock && r_q.axi.wstrb[0]) begin
                            r_d.regs.base_hi = r_q.axi.wdata[BAH_W-1:0];
                        end
                    end
                    OFF_BAL: begin
                        if (r_q.regs.stop && !r_q.regs.lock) begin
                            r_d.regs.base_lo = merge(r_q.regs.base_lo, r_q.axi.wdata,
                                                     r_q.axi.wstrb);
                        end
                    end
                    default: r_d.regs = r_q.regs;
                endcase
            end
        end
        if (s_rvalid && s_rready) begin
            r_d.axi.rvalid = 1'b0;
        end
        if (s_arvalid && s_arready) begin
            r_d.axi.rvalid = 1'b1;
            r_d.axi.rdata = hidden ? READ_ZERO : reg_read(r_q.regs, s_araddr);
        end

        if (rst_apply) begin
            r_d.pend = 1'b0;
            r_d.regs.stop = STOP_RST;
            r_d.regs.lock = LOCK_RST;
            r_d.regs.space = SPACE_RST;
            r_d.regs.test = TST_RST;
            r_d.regs.base_hi = BAH_RST;
            r_d.regs.base_lo = BAL_RST;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r_q <= '0;
            r_q.st <= ST_IDLE;
            r_q.regs.stop <= STOP_RST;
            r_q.regs.lock <= LOCK_RST;
            r_q.regs.space <= SPACE_RST;
        end else begin
            r_q <= r_d;
        end
    end

    assign ack_o = r_q.ack;
    assign abort_o = r_q.abort;
    assign rdata_o = r_q.rdata;
    assign s_awready = !r_q.axi.aw_held;
    assign s_wready = !r_q.axi.w_held;
    assign s_bvalid = r_q.axi.bvalid;
    assign s_bresp = AXI_OKAY;
    assign s_arready = !r_q.axi.rvalid;
    assign s_rvalid = r_q.axi.rvalid;
    assign s_rdata = r_q.axi.rdata;
    assign s_rresp = AXI_OKAY;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_bus_cycle;
        r_q.st == ST_FETCH ##1 r_q.st == ST_LATCH;
    endsequence

    sequence s_two_bus_cycles;
        s_bus_cycle ##1 s_bus_cycle;
    endsequence

    a_short_access: assert property (accept && !need_two_in |=> s_bus_cycle ##1 ack_o)
        else $error("byte or aligned word did not finish in one bus cycle");
    a_split_word: assert property (accept && need_two_in && req_data_i.size == SZ_WORD
                                   |=> s_two_bus_cycles ##1 (ack_o && !abort_o))
        else $error("misaligned word did not take two bus cycles");
    a_standby_refused: assert property (standby_supply_i && r_q.st == ST_IDLE
                                        |=> r_q.st == ST_IDLE)
        else $error("array access taken on standby supply");
    a_stop_silent: assert property (r_q.regs.stop && r_q.st == ST_IDLE
                                    |=> r_q.st == ST_IDLE)
        else $error("array access taken while stopped");
    a_space_gate: assert property (r_q.st == ST_IDLE && r_q.regs.space[0]
                                   && !req_data_i.prog_space |=> r_q.st == ST_IDLE)
        else $error("data access taken in program-only space");
    a_lock_sticky: assert property (r_q.regs.lock && !rst_apply |=> r_q.regs.lock)
        else $error("lock bit cleared without reset");
    a_base_guarded: assert property (!(r_q.regs.stop && !r_q.regs.lock) && !rst_apply
                                     |=> $stable(r_q.regs.base_hi)
                                         && $stable(r_q.regs.base_lo))
        else $error("base changed while locked or running");
    a_reset_values: assert property (rst_apply |=> r_q.regs.stop && !r_q.regs.lock
                                     && base == '0 && !r_q.regs.space[0])
        else $error("synchronous reset left wrong register values");
    a_long_cut: assert property (r_q.st == ST_LATCH && !r_q.cyc && r_q.req.size == SZ_LONG
                                 && rst_hit |=> ack_o && abort_o)
        else $error("long word not cut after first half on reset");
    a_reset_waits: assert property (r_q.st != ST_IDLE && r_q.req.size != SZ_LONG
                                    |=> $stable(r_q.regs.base_lo) || r_q.axi.bvalid)
        else $error("reset acted during a byte or word access");
    a_unmapped_zero: assert property (s_arvalid && s_arready && s_araddr > OFF_BAL
                                      |=> s_rdata == READ_ZERO)
        else $error("unused register location did not read zero");
endmodule

//--- shared/srm_pkg.sv
package srm_pkg;

    localparam int unsigned ADDR_W = 24;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned HALF_W = 16;
    localparam int unsigned AXI_AW = 5;

    // Register word offsets on the AXI4-Lite window.
    localparam logic [AXI_AW-1:0] OFF_CFG = 5'h00;
    localparam logic [AXI_AW-1:0] OFF_TST = 5'h04;
    localparam logic [AXI_AW-1:0] OFF_BAH = 5'h08;
    localparam logic [AXI_AW-1:0] OFF_BAL = 5'h0c;

    // Field positions in the configuration register, and the width of the high base register.
    localparam int unsigned CFG_STOP_BIT = 15;
    localparam int unsigned CFG_LOCK_BIT = 11;
    localparam int unsigned CFG_SPACE_LSB = 8;
    localparam int unsigned BAH_W = 8;

    // Reset values.
    localparam logic STOP_RST = 1'b1;
    localparam logic LOCK_RST = 1'b0;
    localparam logic [1:0] SPACE_RST = 2'h0;
    localparam logic [HALF_W-1:0] TST_RST = 16'h0000;
    localparam logic [BAH_W-1:0] BAH_RST = 8'h00;
    localparam logic [HALF_W-1:0] BAL_RST = 16'h0000;

    // One bus cycle is one fetch clock plus one latch clock.
    localparam int unsigned BUS_CYCLE_CLKS = 2;

    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} srm_size_e;

    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_LATCH} srm_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        srm_size_e size;
        logic write;
        logic prog_space;
        logic [DATA_W-1:0] wdata;
    } srm_req_s;

    typedef struct packed {
        logic stop;
        logic lock;
        logic [1:0] space;
        logic [HALF_W-1:0] test;
        logic [BAH_W-1:0] base_hi;
        logic [HALF_W-1:0] base_lo;
    } srm_regs_s;

    typedef struct packed {
        logic aw_held;
        logic [AXI_AW-1:0] awaddr;
        logic w_held;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
    } srm_axi_s;

    typedef struct packed {
        srm_state_e st;
        logic cyc;
        srm_req_s req;
        logic [DATA_W-1:0] rdata;
        logic ack;
        logic abort;
        logic pend;
        srm_regs_s regs;
        srm_axi_s axi;
    } srm_state_s;

endpackage

//--- logic/srm_word_ram.sv
`timescale 1ns/1ps
module srm_word_ram
    import srm_pkg::*;
#(
    parameter int unsigned IDX_W = 9
) (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Word port.
    input wire logic en_i,
    input wire logic we_i,
    input wire logic [1:0] be_i,
    input wire logic [IDX_W-1:0] idx_i,
    input wire logic [HALF_W-1:0] wd_i,
    output logic [HALF_W-1:0] rd_o
);
    logic [HALF_W-1:0] mem [2**IDX_W];

    // The array is not reset: its contents survive any reset.
    always_ff @(posedge clk_sys_i) begin
        if (en_i && we_i && be_i[1]) begin
            mem[idx_i][15:8] <= wd_i[15:8];
        end
        if (en_i && we_i && be_i[0]) begin
            mem[idx_i][7:0] <= wd_i[7:0];
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_o <= '0;
        end else if (en_i) begin
            rd_o <= mem[idx_i];
        end
    end
endmodule

//--- testbench/srm_bus_master.sv
`timescale 1ns/1ps
module srm_bus_master
    import srm_pkg::*;
(
    // Clock.
    input wire logic clk_sys_i,
    // Array port towards the block.
    output logic req_o,
    output srm_req_s req_data_o,
    input wire logic ack_i,
    input wire logic abort_i,
    input wire logic [DATA_W-1:0] rdata_i
);
    logic [DATA_W-1:0] last_rd;
    logic last_ab;
    int last_n;

    initial begin
        req_o = 1'b0;
        req_data_o = '0;
        last_rd = '0;
        last_ab = 1'b0;
        last_n = 0;
    end

    // Callers pick bases outside the unreachable range; the mapping bit is cleared only to check that a request is refused.
    task automatic xfer(input logic [ADDR_W-1:0] a, input srm_size_e sz, input logic wr,
                        input logic pg, input logic [DATA_W-1:0] wd);
        int n;
        n = 0;
        last_n = 0;
        @(posedge clk_sys_i);
        req_o <= 1'b1;
        req_data_o <= '{addr: a, size: sz, write: wr, prog_space: pg, wdata: wd};
        while (n < 24) begin
            @(posedge clk_sys_i);
            n++;
            if (ack_i === 1'b1) begin
                last_n = n;
                last_rd = rdata_i;
                last_ab = abort_i;
                break;
            end
        end
        // A refused request is never answered, so the master gives up after a fixed wait.
        req_o <= 1'b0;
        req_data_o <= ~req_data_o;
    endtask
endmodule

//--- testbench/tb_standby_ram_module.sv
`timescale 1ns/1ps
module tb_standby_ram_module
    import srm_pkg::*;
;
    localparam logic [ADDR_W-1:0] BASE = 24'h010400;
    logic clk_sys_i, resetn_i, sync_rst_i, standby_supply_i, module_mapping_bit_i;
    logic req_i, ack_o, abort_o;
    srm_req_s req_data;
    logic [DATA_W-1:0] rdata_o, s_wdata, s_rdata;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready;
    logic [AXI_AW-1:0] s_awaddr, s_araddr;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp;
    int err_total, cmp_count, cyc, nb;

    srm_top uut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .sync_rst_i(sync_rst_i),
        .standby_supply_i(standby_supply_i), .module_mapping_bit_i(module_mapping_bit_i),
        .req_i(req_i), .req_data_i(req_data), .ack_o(ack_o), .abort_o(abort_o),
        .rdata_o(rdata_o), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_awaddr(s_awaddr), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_wdata(s_wdata),
        .s_wstrb(s_wstrb), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp),
        .s_arvalid(s_arvalid), .s_arready(s_arready), .s_araddr(s_araddr),
        .s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata), .s_rresp(s_rresp));

    srm_bus_master m (.clk_sys_i(clk_sys_i), .req_o(req_i), .req_data_o(req_data),
        .ack_i(ack_o), .abort_i(abort_o), .rdata_i(rdata_o));

    always #12.5 clk_sys_i = ~clk_sys_i;

    task automatic conclude();
        if (err_total == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // The whole sequence needs a few hundred cycles, so this ceiling only trips on a hang.
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            conclude();
        end
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic axi_wr(input logic [AXI_AW-1:0] a, input logic [DATA_W-1:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk_sys_i);
        s_awvalid <= 1'b1;
        s_awaddr <= a;
        s_wvalid <= 1'b1;
        s_wdata <= d;
        s_wstrb <= 4'hf;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk_sys_i);
            if (!aw_ok && s_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_awvalid <= 1'b0;
            end
            if (!w_ok && s_wready === 1'b1) begin
                w_ok = 1'b1;
                s_wvalid <= 1'b0;
            end
        end
        s_bready <= 1'b1;
        do @(posedge clk_sys_i); while (s_bvalid !== 1'b1);
        s_bready <= 1'b0;
        chk("bresp", 32'(s_bresp), 32'(AXI_OKAY));
    endtask

    task automatic rd_chk(input logic [AXI_AW-1:0] a, input logic [31:0] exp, input string nm);
        @(posedge clk_sys_i);
        s_arvalid <= 1'b1;
        s_araddr <= a;
        do @(posedge clk_sys_i); while (s_arready !== 1'b1);
        s_arvalid <= 1'b0;
        s_rready <= 1'b1;
        do @(posedge clk_sys_i); while (s_rvalid !== 1'b1);
        s_rready <= 1'b0;
        chk("rresp", 32'(s_rresp), 32'(AXI_OKAY));
        chk(nm, s_rdata, exp);
    endtask

    task automatic setup();
        axi_wr(OFF_BAH, 32'h0000_0001);
        axi_wr(OFF_BAL, 32'h0000_0400);
    endtask

    task automatic refused(input logic [ADDR_W-1:0] a, input logic pg, input string nm);
        m.xfer(a, SZ_BYTE, 1'b0, pg, 32'h0);
        chk(nm, 32'(m.last_n), 32'h0);
    endtask

    task automatic t_reset_regs();
        rd_chk(OFF_CFG, 32'h0000_8000, "cfg reset");
        rd_chk(OFF_TST, 32'h0, "tst reset");
        rd_chk(OFF_BAH, 32'h0, "bah reset");
        rd_chk(OFF_BAL, 32'h0, "bal reset");
        axi_wr(5'h10, 32'h0000_ffff);
        rd_chk(5'h10, READ_ZERO, "unused");
        axi_wr(OFF_TST, 32'h0000_beef);
        rd_chk(OFF_TST, 32'h0000_beef, "tst");
        setup();
        rd_chk(OFF_BAH, 32'h0000_0001, "bah");
        rd_chk(OFF_BAL, 32'h0000_0400, "bal");
        refused(BASE, 1'b1, "stopped");
    endtask

    task automatic t_access();
        axi_wr(OFF_CFG, 32'h0);
        m.xfer(BASE + 24'h1, SZ_BYTE, 1'b1, 1'b0, 32'h0000_00a5);
        nb = m.last_n;
        chk("byte ack", 32'(nb), 32'(BUS_CYCLE_CLKS + 2));
        m.xfer(BASE + 24'h4, SZ_LONG, 1'b1, 1'b0, 32'h1234_5678);
        chk("long wr lat", 32'(m.last_n), 32'(nb + BUS_CYCLE_CLKS));
        m.xfer(BASE + 24'h1, SZ_BYTE, 1'b0, 1'b0, 32'h0);
        chk("byte rd", m.last_rd, 32'h0000_00a5);
        chk("byte lat", 32'(m.last_n), 32'(nb));
        m.xfer(BASE + 24'h4, SZ_LONG, 1'b0, 1'b0, 32'h0);
        chk("long rd", m.last_rd, 32'h1234_5678);
        m.xfer(BASE + 24'h4, SZ_WORD, 1'b0, 1'b0, 32'h0);
        chk("word rd", m.last_rd, 32'h0000_1234);
        chk("word lat", 32'(m.last_n), 32'(nb));
        m.xfer(BASE + 24'h5, SZ_WORD, 1'b0, 1'b0, 32'h0);
        chk("odd word rd", m.last_rd, 32'h0000_3456);
        chk("odd word lat", 32'(m.last_n), 32'(nb + BUS_CYCLE_CLKS));
        m.xfer(BASE + 24'h9, SZ_WORD, 1'b1, 1'b0, 32'h0000_c3d4);
        m.xfer(BASE + 24'h9, SZ_WORD, 1'b0, 1'b0, 32'h0);
        chk("odd word wr", m.last_rd, 32'h0000_c3d4);
        refused(BASE + 24'h400, 1'b0, "outside");
        axi_wr(OFF_BAH, 32'h0000_0002);
        rd_chk(OFF_BAH, 32'h0000_0001, "bah live");
    endtask

    task automatic t_space_power();
        axi_wr(OFF_CFG, 32'h0000_0100);
        refused(BASE, 1'b0, "data x1");
        m.xfer(BASE, SZ_BYTE, 1'b0, 1'b1, 32'h0);
        chk("prog x1", 32'(m.last_n), 32'(nb));
        axi_wr(OFF_CFG, 32'h0000_0200);
        m.xfer(BASE, SZ_BYTE, 1'b0, 1'b0, 32'h0);
        chk("data x0", 32'(m.last_n), 32'(nb));
        standby_supply_i <= 1'b1;
        refused(BASE, 1'b1, "standby");
        standby_supply_i <= 1'b0;
        module_mapping_bit_i <= 1'b0;
        refused(BASE, 1'b1, "mapping");
        module_mapping_bit_i <= 1'b1;
    endtask

    task automatic t_lock();
        axi_wr(OFF_CFG, 32'h0000_8800);
        rd_chk(OFF_CFG, 32'h0000_8800, "lock set");
        axi_wr(OFF_CFG, 32'h0000_8000);
        rd_chk(OFF_CFG, 32'h0000_8800, "lock held");
        axi_wr(OFF_BAL, 32'h0000_0800);
        rd_chk(OFF_BAL, 32'h0000_0400, "bal locked");
    endtask

    task automatic t_sync(input srm_size_e sz, input int k, input logic ab, input int n);
        axi_wr(OFF_CFG, 32'h0);
        fork
            m.xfer(BASE, sz, 1'b0, 1'b0, 32'h0);
            begin
                repeat (k) @(posedge clk_sys_i);
                sync_rst_i <= 1'b1;
                @(posedge clk_sys_i);
                sync_rst_i <= 1'b0;
            end
        join
        chk("abort", 32'(m.last_ab), 32'(ab));
        chk("sync lat", 32'(m.last_n), 32'(n));
        rd_chk(OFF_CFG, 32'h0000_8000, "cfg sync");
        setup();
        rd_chk(OFF_BAL, 32'h0000_0400, "unlocked");
    endtask

    task automatic t_overlap();
        axi_wr(OFF_BAH, 32'h0000_00ff);
        axi_wr(OFF_BAL, 32'h0000_f800);
        axi_wr(OFF_CFG, 32'h0);
        rd_chk(OFF_CFG, READ_ZERO, "overlap");
    endtask

    initial begin
        clk_sys_i = 1'b0;
        resetn_i = 1'b0;
        {sync_rst_i, standby_supply_i} = '0;
        module_mapping_bit_i = 1'b1;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
        {err_total, cmp_count, cyc, nb} = '0;
        repeat (4) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        t_reset_regs();
        t_access();
        t_space_power();
        t_lock();
        t_sync(SZ_BYTE, 2, 1'b0, nb);
        t_sync(SZ_LONG, 2, 1'b1, nb);
        t_sync(SZ_LONG, 4, 1'b0, nb + BUS_CYCLE_CLKS);
        t_overlap();
        conclude();
    end
endmodule
